/* src/ldc_params.svh */
/*
  Timing counts, levels and encodings for the LED dimming and pump mode control.
  Assumes a 10 MHz system clock.
*/
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH

`define LDC_CLK_HZ 10000000
`define LDC_CLK_NS 100
// Shutdown low time window, microseconds
`define LDC_SHDN_MIN_US 12500
`define LDC_SHDN_TYP_US 20000
`define LDC_SHDN_MAX_US 30000
`define LDC_SHDN_CYC ((`LDC_SHDN_TYP_US * (`LDC_CLK_HZ / 1000000)))
// Shortest dimming pulse honoured, nanoseconds
`define LDC_PULSE_MIN_NS 200
`define LDC_PULSE_MIN_CYC ((`LDC_PULSE_MIN_NS + `LDC_CLK_NS - 1) / `LDC_CLK_NS)
// Level count
`define LDC_LEVELS 32
`define LDC_LEVEL_W 5
`define LDC_LEVEL_FULL 5'h00
`define LDC_LEVEL_LAST 5'h1F
`define LDC_CHANNELS 6
// Current code width: 25*(32-n)/32 expressed as (32-n), 0..32
`define LDC_CODE_W 6
`define LDC_CODE_FULL 6'h20

`endif

/* src/ldc_pkg.sv */
/*
  Types for the LED dimming and pump mode control.
  Assumes ldc_params.svh is included before use.
*/
`include "ldc_params.svh"

package ldc_pkg;

  typedef enum logic [1:0] {
    LDC_GAIN_1X,
    LDC_GAIN_1P33X,
    LDC_GAIN_1P5X,
    LDC_GAIN_2X
  } ldc_gain_t;

  typedef enum logic [1:0] {
    LDC_ST_SHUTDOWN,
    LDC_ST_ACTIVE
  } ldc_mode_t;

  typedef struct packed {
    logic [2:0] dim_sync;
    logic [2:0] gate_sync;
    logic dim_q;
    logic gate_q;
    logic [`LDC_LEVEL_W-1:0] hi_cnt;
  } ldc_inputs_t;

  typedef struct packed {
    ldc_inputs_t inp;
    ldc_mode_t mode;
    ldc_gain_t gain;
    logic [`LDC_LEVEL_W-1:0] pulses;
    logic [31:0] dim_low_cnt;
    logic [31:0] gate_low_cnt;
    logic [`LDC_CHANNELS-1:0] sink_en;
    logic [`LDC_CODE_W-1:0] code;
    logic pump_on;
  } ldc_state_t;

endpackage : ldc_pkg

/* src/ldc_core.sv */
/*
  Digital control of a six channel LED driver: charge pump gain stepping,
  one-wire pulse dimming over 32 levels, duty gate and low-time shutdown.
  Assumes the analog side reports regulation headroom and undervoltage as
  asynchronous levels, and turns the current code into sink current.
*/
// How it works
// R1: After reset the pump starts in unity gain.
// R2: Pump stays in unity while every channel regulates.
// R3: Loss of regulation in unity moves the pump to 1.33x.
// R4: Further loss steps to 1.5x, then 2x, the highest gain.
// R5: Recovery at unity headroom jumps straight back to unity gain.
// R6: Undervoltage disables all channels and enters shutdown.
// R7: First dimming rising edge after shutdown enables all channels at full scale.
// R8: Each later dimming pulse lowers the level by one thirty-second.
// R9: Act on rising edges; after the 31st step the next wraps to full.
// R10: Current code is 32 minus the pulse count, in 25/32 mA units.
// R11: Host keeps pulses 200 ns to 100 us; shorter ones are filtered.
// R12: Gate high drives all channels at the programmed level.
// R13: Gate low forces every channel current to zero.
// R14: Either input low for about 20 ms enters shutdown.
// R15: Shutdown low-time detection lies between 12.5 ms and 30 ms.
// R16: In shutdown all channel outputs are high impedance and zero current.
// R17: Entering shutdown clears the pulse count and returns pump to unity.
`timescale 1ns/1ps
`include "ldc_params.svh"

module ldc_core
  import ldc_pkg::*;
#(
  parameter int SHDN_CYCLES = `LDC_SHDN_CYC,
  parameter int PULSE_MIN_CYCLES = `LDC_PULSE_MIN_CYC
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Host pins
  input wire logic i_dim_pulse_in,
  input wire logic i_duty_gate_in,
  // Analog status
  input wire logic i_pump_supply_uvlo,
  input wire logic i_regulation_lost,
  input wire logic i_unity_headroom_ok,
  // Outputs
  output logic [1:0] o_pump_gain,
  output logic o_pump_on,
  output logic [`LDC_CHANNELS-1:0] o_led_channel_sinks_en,
  output logic [`LDC_CODE_W-1:0] o_led_current_code,
  output logic o_shutdown
);

  logic [2:0] uv_sync_r;
  logic [2:0] rl_sync_r;
  logic [2:0] hr_sync_r;
  ldc_state_t st_r;
  ldc_state_t st_nxt;

  // Three stage filter: a level counts once stages two and three agree
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction : agreed

  logic uv_q_r;
  logic rl_q_r;
  logic hr_q_r;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      uv_sync_r <= 3'h0;
      rl_sync_r <= 3'h0;
      hr_sync_r <= 3'h0;
      uv_q_r <= 1'b0;
      rl_q_r <= 1'b0;
      hr_q_r <= 1'b0;
    end
    else
    begin
      uv_sync_r <= {uv_sync_r[1:0], i_pump_supply_uvlo};
      rl_sync_r <= {rl_sync_r[1:0], i_regulation_lost};
      hr_sync_r <= {hr_sync_r[1:0], i_unity_headroom_ok};
      uv_q_r <= agreed(uv_sync_r, uv_q_r);
      rl_q_r <= agreed(rl_sync_r, rl_q_r);
      hr_q_r <= agreed(hr_sync_r, hr_q_r);
    end
  end

  always_comb
  begin
    logic dim_rise;
    logic dim_new;
    logic gate_new;
    logic shdn_req;
    dim_rise = 1'b0;
    dim_new = 1'b0;
    gate_new = 1'b0;
    shdn_req = 1'b0;
    st_nxt = st_r;

    st_nxt.inp.dim_sync = {st_r.inp.dim_sync[1:0], i_dim_pulse_in};
    st_nxt.inp.gate_sync = {st_r.inp.gate_sync[1:0], i_duty_gate_in};
    dim_new = agreed(st_r.inp.dim_sync, st_r.inp.dim_q);
    gate_new = agreed(st_r.inp.gate_sync, st_r.inp.gate_q);
    st_nxt.inp.gate_q = gate_new;

    // Glitch filter: a high shorter than the minimum is not a pulse
    if (dim_new && st_r.inp.hi_cnt != `LDC_LEVEL_LAST)
      st_nxt.inp.hi_cnt = st_r.inp.hi_cnt + 5'h01;
    else if (!dim_new)
      st_nxt.inp.hi_cnt = 5'h00;
    if (dim_new && !st_r.inp.dim_q)
      st_nxt.inp.dim_q = 1'b1;
    else if (!dim_new)
      st_nxt.inp.dim_q = 1'b0;
    dim_rise = dim_new && (st_r.inp.hi_cnt == 5'(PULSE_MIN_CYCLES - 1)); // R9 R11

    // Low-time counters, saturating
    if (dim_new)
      st_nxt.dim_low_cnt = 32'h0;
    else if (st_r.dim_low_cnt < 32'(SHDN_CYCLES))
      st_nxt.dim_low_cnt = st_r.dim_low_cnt + 32'h1;
    if (gate_new)
      st_nxt.gate_low_cnt = 32'h0;
    else if (st_r.gate_low_cnt < 32'(SHDN_CYCLES))
      st_nxt.gate_low_cnt = st_r.gate_low_cnt + 32'h1;
    shdn_req = (st_r.dim_low_cnt >= 32'(SHDN_CYCLES))
      || (st_r.gate_low_cnt >= 32'(SHDN_CYCLES)); // R14 R15

    case (st_r.mode)
      LDC_ST_SHUTDOWN:
      begin
        st_nxt.gain = LDC_GAIN_1X; // R17
        st_nxt.pulses = `LDC_LEVEL_FULL; // R17
        if (dim_rise && !uv_q_r)
        begin
          st_nxt.mode = LDC_ST_ACTIVE; // R7
          st_nxt.dim_low_cnt = 32'h0;
          st_nxt.gate_low_cnt = 32'h0;
        end
      end
      LDC_ST_ACTIVE:
      begin
        if (uv_q_r || shdn_req)
        begin
          st_nxt.mode = LDC_ST_SHUTDOWN; // R6 R14
          st_nxt.gain = LDC_GAIN_1X; // R17
          st_nxt.pulses = `LDC_LEVEL_FULL; // R17
        end
        else
        begin
          if (dim_rise)
            st_nxt.pulses = st_r.pulses + 5'h01; // R8 R9
          // Headroom wins over loss above unity; at unity, loss with headroom still steps the pump to 1.33x
          if (hr_q_r && st_r.gain != LDC_GAIN_1X)
            st_nxt.gain = LDC_GAIN_1X; // R5
          else if (rl_q_r)
          begin
            case (st_r.gain)
              LDC_GAIN_1X: st_nxt.gain = LDC_GAIN_1P33X; // R3
              LDC_GAIN_1P33X: st_nxt.gain = LDC_GAIN_1P5X; // R4
              LDC_GAIN_1P5X: st_nxt.gain = LDC_GAIN_2X; // R4
              default: st_nxt.gain = LDC_GAIN_2X;
            endcase
          end
          else
            st_nxt.gain = st_r.gain; // R2
        end
      end
      default:
        st_nxt.mode = LDC_ST_SHUTDOWN;
    endcase

    st_nxt.pump_on = (st_nxt.mode == LDC_ST_ACTIVE);
    st_nxt.sink_en = (st_nxt.mode == LDC_ST_ACTIVE) ? {`LDC_CHANNELS{1'b1}} : '0; // R16
    if (st_nxt.mode == LDC_ST_ACTIVE && gate_new)
      st_nxt.code = `LDC_CODE_FULL - {1'b0, st_nxt.pulses}; // R10 R12
    else
      st_nxt.code = 6'h00; // R13 R16
  end

  // Limitation: a level change takes effect once the pulse has been high 200 ns
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_r <= '0;
      st_r.mode <= LDC_ST_SHUTDOWN;
      st_r.gain <= LDC_GAIN_1X; // R1
    end
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pump_gain <= 2'h0;
      o_pump_on <= 1'b0;
      o_led_channel_sinks_en <= '0;
      o_led_current_code <= 6'h00;
      o_shutdown <= 1'b1;
    end
    else
    begin
      o_pump_gain <= st_nxt.gain;
      o_pump_on <= st_nxt.pump_on;
      o_led_channel_sinks_en <= st_nxt.sink_en;
      o_led_current_code <= st_nxt.code;
      o_shutdown <= (st_nxt.mode == LDC_ST_SHUTDOWN);
    end
  end

endmodule : ldc_core

/* verification/ldc_core_chk.sv */
/* Port checker for ldc_core.
   Bound to every ldc_core; sees its ports only. */
`timescale 1ns/1ps
module ldc_core_chk #(parameter int SHDN_CYCLES = 200)
(
  // Clock, reset, inputs
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_dim_pulse_in,
  input wire logic i_duty_gate_in,
  input wire logic i_pump_supply_uvlo,
  input wire logic i_regulation_lost,
  input wire logic i_unity_headroom_ok,
  // Outputs
  input wire logic [1:0] o_pump_gain,
  input wire logic o_pump_on,
  input wire logic [5:0] o_led_channel_sinks_en,
  input wire logic [5:0] o_led_current_code,
  input wire logic o_shutdown
);
  // Slack of 8 covers the input filter
  localparam int LIM = SHDN_CYCLES + 8;
  int dlow;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b)
      dlow <= 0;
    else
      dlow <= i_dim_pulse_in ? 0 : dlow + 1;
  sequence s_climb;
    (i_regulation_lost && !i_unity_headroom_ok && !o_shutdown) [*8];
  endsequence
  sequence s_wake;
    i_duty_gate_in [*8] ##0 $fell(o_shutdown);
  endsequence
  a_pump_climb: assert property (s_climb |-> ##[0:4] o_pump_gain == 2'h3)
    else $error("gain did not reach 2x");
  a_gain_no_down: assert property ($changed(o_pump_gain) |-> o_pump_gain == 2'h0 ||
    o_pump_gain == $past(o_pump_gain) + 2'h1) else $error("gain stepped down");
  a_uvlo_off: assert property (i_pump_supply_uvlo [*6] |-> ##[0:3] o_shutdown)
    else $error("no shutdown on undervoltage");
  a_wake_full: assert property (s_wake |-> o_led_current_code == 6'h20)
    else $error("wake not at full scale");
  a_dim_step: assert property (!o_shutdown && !$past(o_shutdown) && $changed(o_led_current_code)
    && $past(o_led_current_code) != 6'h00 && o_led_current_code != 6'h00 |-> o_led_current_code ==
    ($past(o_led_current_code) == 6'h01 ? 6'h20 : $past(o_led_current_code) - 6'h01)) else $error("bad step");
  a_gate_zero: assert property ((!i_duty_gate_in) [*6] |-> ##[0:2] o_led_current_code == 6'h00)
    else $error("current not zero with gate low");
  a_low_timeout: assert property (dlow > LIM |-> o_shutdown)
    else $error("no shutdown after long low");
  a_shdn_zero: assert property (o_shutdown |-> o_led_channel_sinks_en == 6'h00 &&
    o_led_current_code == 6'h00 && o_pump_gain == 2'h0 && !o_pump_on) else $error("shutdown not quiet");
endmodule : ldc_core_chk

bind ldc_core ldc_core_chk #(.SHDN_CYCLES(SHDN_CYCLES)) u_ldc_core_chk (.*);

/* verification/ldc_host.sv */
/* Host model driving the dimming and duty gate pins.
   Called from the bench at falling edges; starts with dimming low, and a pulse leaves it high. */
`timescale 1ns/1ps
module ldc_host
(
  // Clock
  input wire logic i_clock,
  // Host pins
  output logic o_dim,
  output logic o_gate
);
  task set(input logic d, input logic g);
    o_dim = d;
    o_gate = g;
  endtask : set
  // Low then high; both widths stay inside 200 ns to 100 us
  task pulse(input int lo, input int hi);
    o_dim = 1'b0;
    repeat (lo) @(negedge i_clock);
    o_dim = 1'b1;
    repeat (hi) @(negedge i_clock);
  endtask : pulse
  initial
  begin
    set(1'b0, 1'b1);
  end
endmodule : ldc_host

/* verification/tb_top.sv */
/* Self-checking bench for ldc_core with the host model on its pins.
   Shutdown count scaled to SHDN cycles; expectations follow from it. */
`timescale 1ns/1ps
module tb_top;
  localparam int SHDN = 200;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_dim_pulse_in;
  logic i_duty_gate_in;
  logic i_pump_supply_uvlo = 1'b0;
  logic i_regulation_lost = 1'b0;
  logic i_unity_headroom_ok = 1'b0;
  logic [1:0] o_pump_gain;
  logic o_pump_on;
  logic [5:0] o_led_channel_sinks_en;
  logic [5:0] o_led_current_code;
  logic o_shutdown;
  int err_count = 0;
  int cmp_count = 0;
  ldc_core #(.SHDN_CYCLES(SHDN)) u_ldc_core (.*);
  ldc_host u_ldc_host (.i_clock(i_clock), .o_dim(i_dim_pulse_in), .o_gate(i_duty_gate_in));
  initial
  begin
    forever #50 i_clock = ~i_clock;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task wait_shdn(input int lim);
    for (int i = 0; i < lim && o_shutdown !== 1'b1; i++)
      @(negedge i_clock);
    if (o_shutdown !== 1'b1)
    begin
      err_count++;
      report_and_stop;
    end
  endtask : wait_shdn
  task t_dim;
    u_ldc_host.pulse(4, 8);
    chk(o_led_current_code, 8'h20);
    chk(o_led_channel_sinks_en, 8'h3F);
    chk(o_pump_on, 8'h01);
    chk(o_shutdown, 8'h00);
    for (int k = 1; k <= 32; k++)
    begin
      u_ldc_host.pulse(4, 8);
      chk(o_led_current_code, k == 32 ? 8'h20 : 8'h20 - k[7:0]);
    end
  endtask : t_dim
  task t_pump;
    chk(o_pump_gain, 8'h00);
    i_regulation_lost = 1'b1;
    repeat (10) @(negedge i_clock);
    chk(o_pump_gain, 8'h03);
    i_regulation_lost = 1'b0;
    i_unity_headroom_ok = 1'b1;
    repeat (8) @(negedge i_clock);
    chk(o_pump_gain, 8'h00);
    i_unity_headroom_ok = 1'b0;
    u_ldc_host.set(1'b1, 1'b0);
    repeat (8) @(negedge i_clock);
    chk(o_led_current_code, 8'h00);
    u_ldc_host.set(1'b1, 1'b1);
    repeat (8) @(negedge i_clock);
    chk(o_led_current_code, 8'h20);
  endtask : t_pump
  // Count and gain left nonzero so the clear on shutdown shows
  task t_shdn(input logic by_gate);
    i_regulation_lost = 1'b1;
    u_ldc_host.pulse(4, 8);
    i_regulation_lost = 1'b0;
    u_ldc_host.set(by_gate, !by_gate);
    repeat (SHDN * 5 / 8 - 1) @(negedge i_clock);
    chk(o_shutdown, 8'h00);
    wait_shdn(SHDN * 7 / 8);
    chk(o_led_channel_sinks_en, 8'h00);
    chk(o_pump_gain, 8'h00);
    u_ldc_host.set(1'b0, 1'b1);
    @(negedge i_clock);
    u_ldc_host.pulse(4, 8);
    chk(o_led_current_code, 8'h20);
    chk(o_pump_on, 8'h01);
  endtask : t_shdn
  task t_uvlo;
    i_pump_supply_uvlo = 1'b1;
    wait_shdn(8);
    repeat (4) @(negedge i_clock);
    chk(o_led_channel_sinks_en, 8'h00);
    i_pump_supply_uvlo = 1'b0;
    repeat (4) @(negedge i_clock);
    u_ldc_host.pulse(4, 8);
    chk(o_led_current_code, 8'h20);
  endtask : t_uvlo
  initial
  begin
    repeat (4) @(negedge i_clock);
    i_rst_b = 1'b1;
    chk(o_shutdown, 8'h01);
    chk(o_pump_gain, 8'h00);
    t_dim;
    t_pump;
    t_shdn(1'b0);
    t_shdn(1'b1);
    t_uvlo;
    report_and_stop;
  end
endmodule : tb_top
